// ---- hdl/tcp_pkg.sv ----
// constants for the cascadable timer pair
// Function
// RQ1: cascade joins low word and high word
// RQ2: cascade ignores the high half control
// RQ3: low half clock and gate drive cascade
// RQ4: cascade interrupt uses high half flag
// RQ5: interrupt on full 32-bit period match
// RQ6: halves count independently when not cascaded
// RQ7: no asynchronous external counter mode exists
// RQ8: only low half resynchronises prescaler output
// RQ9: timer mode counts cycles, wraps at period
// RQ10: counter mode counts synced external edges
// RQ11: low count read latches high count
// RQ12: holding write then low write loads high
// RQ13: stop-in-idle bit halts counting in idle
// RQ14: counting resumes when idle ends
// RQ15: adc trigger, gating and prescaler ratios
// RQ16: cascade compares all 32 bits together
package tcp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTL_LO = 8'h00;
  localparam logic [7:0] OFS_CTL_HI = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] OFS_PER_LO = 8'h10;
  localparam logic [7:0] OFS_PER_HI = 8'h14;
  localparam logic [7:0] OFS_HOLD = 8'h18;
  localparam logic [7:0] OFS_STS = 8'h1C;
  localparam logic [7:0] OFS_MSK = 8'h20;
  // control fields
  localparam int CTL_ON = 15;
  localparam int CTL_SIDL = 13;
  localparam int CTL_GATE = 6;
  localparam int CTL_PS = 4;
  localparam int CTL_CASC = 3;
  localparam int CTL_EXT = 1;
  localparam logic [15:0] CTL_MASK = 16'hA07A;
  // status fields
  localparam int STS_LO = 0;
  localparam int STS_HI = 1;
  // reset values
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hFFFF;
  // prescaler terminal counts for 1, 8, 64, 256
  localparam logic [7:0] PS_LIM [0:3] = '{8'h00, 8'h07, 8'h3F, 8'hFF};
endpackage

// ---- hdl/tcp_timer_pair.sv ----
// two 16-bit timers, cascadable to 32 bits, ahb-lite slave
`timescale 1ns/10ps
module tcp_timer_pair (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // pins and system state
  input wire logic i_ext_clk_lo,
  input wire logic i_ext_clk_hi,
  input wire logic i_idle,
  // events
  output logic o_adc_trig,
  output logic o_irq
);
  typedef struct packed {
    logic [15:0] ctl_lo;
    logic [15:0] ctl_hi;
    logic [15:0] cnt_lo;
    logic [15:0] cnt_hi;
    logic [15:0] per_lo;
    logic [15:0] per_hi;
    logic [15:0] hold;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [7:0] pre_lo;
    logic [7:0] pre_hi;
    logic tick_lo;
    logic [2:0] sy_lo;
    logic [2:0] sy_hi;
    logic lv_lo;
    logic lv_hi;
    logic ap_vld;
    logic ap_wr;
    logic [7:0] ap_adr;
    logic [31:0] rdata;
    logic adc;
  } tcp_state_t;

  tcp_state_t st_ff;
  tcp_state_t nxt_st;
  logic casc;
  logic rise_lo;
  logic rise_hi;
  logic hit_lo;
  logic hit_hi;
  logic [7:0] pre_hi_v;
  logic [1:0] set_v;
  logic [1:0] clr_v;
  logic wr;
  logic wr_cnt;
  logic wr_lo;
  logic rd_acc;
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic [15:0] wd;

  // prescaler step: returns {hit, next prescale count}
  function automatic logic [8:0] tcp_pre(input logic [15:0] c,
      input logic [7:0] pre, input logic lvl, input logic rise,
      input logic idle);
    logic run;
    logic ev;
    logic [7:0] lim;
    run = c[tcp_pkg::CTL_ON] & ~(idle & c[tcp_pkg::CTL_SIDL]); // RQ13 RQ14
    // external source is always resynchronised: no async mode
    ev = c[tcp_pkg::CTL_EXT] ? rise : // RQ7 RQ10
      (c[tcp_pkg::CTL_GATE] ? lvl : 1'b1); // RQ15
    lim = tcp_pkg::PS_LIM[c[tcp_pkg::CTL_PS+:2]]; // RQ15
    if (!c[tcp_pkg::CTL_ON])
      tcp_pre = 9'h000;
    else if (run && ev)
      tcp_pre = (pre == lim) ? 9'h100 : {1'b0, pre + 8'h01};
    else
      tcp_pre = {1'b0, pre};
  endfunction

  function automatic logic [31:0] tcp_rd(input tcp_state_t s,
      input logic [7:0] a);
    tcp_rd = 32'h0000_0000;
    unique case (a)
      tcp_pkg::OFS_CTL_LO: tcp_rd = {16'h0000, s.ctl_lo};
      tcp_pkg::OFS_CTL_HI: tcp_rd = {16'h0000, s.ctl_hi};
      tcp_pkg::OFS_CNT_LO: tcp_rd = {16'h0000, s.cnt_lo};
      tcp_pkg::OFS_CNT_HI: tcp_rd = {16'h0000, s.cnt_hi};
      tcp_pkg::OFS_PER_LO: tcp_rd = {16'h0000, s.per_lo};
      tcp_pkg::OFS_PER_HI: tcp_rd = {16'h0000, s.per_hi};
      tcp_pkg::OFS_HOLD: tcp_rd = {16'h0000, s.hold};
      tcp_pkg::OFS_STS: tcp_rd = {30'h0000_0000, s.sts};
      tcp_pkg::OFS_MSK: tcp_rd = {30'h0000_0000, s.msk};
      default: tcp_rd = 32'h0000_0000;
    endcase
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    set_v = 2'h0;
    clr_v = 2'h0;
    wd = i_hwdata[15:0];
    casc = st_ff.ctl_lo[tcp_pkg::CTL_CASC];
    cnt32 = {st_ff.cnt_hi, st_ff.cnt_lo}; // RQ1
    per32 = {st_ff.per_hi, st_ff.per_lo};
    wr = st_ff.ap_vld & st_ff.ap_wr;
    wr_lo = wr & (st_ff.ap_adr == tcp_pkg::OFS_CNT_LO);
    wr_cnt = wr_lo | (wr & (st_ff.ap_adr == tcp_pkg::OFS_CNT_HI));
    rd_acc = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
    // pin level changes once second and third stages agree
    nxt_st.sy_lo = {st_ff.sy_lo[1:0], i_ext_clk_lo};
    nxt_st.sy_hi = {st_ff.sy_hi[1:0], i_ext_clk_hi};
    rise_lo = (st_ff.sy_lo[1] == st_ff.sy_lo[2]) & st_ff.sy_lo[2]
      & ~st_ff.lv_lo;
    rise_hi = (st_ff.sy_hi[1] == st_ff.sy_hi[2]) & st_ff.sy_hi[2]
      & ~st_ff.lv_hi;
    if (st_ff.sy_lo[1] == st_ff.sy_lo[2])
      nxt_st.lv_lo = st_ff.sy_lo[2];
    if (st_ff.sy_hi[1] == st_ff.sy_hi[2])
      nxt_st.lv_hi = st_ff.sy_hi[2];
    // low control, clock and gate also serve the cascade
    {hit_lo, nxt_st.pre_lo} = tcp_pre(st_ff.ctl_lo, st_ff.pre_lo,
      st_ff.lv_lo, rise_lo, i_idle); // RQ3
    {hit_hi, pre_hi_v} = tcp_pre(st_ff.ctl_hi, st_ff.pre_hi,
      st_ff.lv_hi, rise_hi, i_idle); // RQ6
    // high half control has no effect while cascaded
    nxt_st.pre_hi = casc ? 8'h00 : pre_hi_v; // RQ2
    // low half retimes its prescaler output; high half uses it direct
    nxt_st.tick_lo = hit_lo; // RQ8
    nxt_st.adc = 1'b0;
    if (casc)
    begin
      if (st_ff.tick_lo)
      begin
        if (cnt32 == per32) // RQ16
        begin
          {nxt_st.cnt_hi, nxt_st.cnt_lo} = 32'h0000_0000; // RQ9 RQ10
          set_v[tcp_pkg::STS_HI] = 1'b1; // RQ4 RQ5
          nxt_st.adc = 1'b1; // RQ15
        end
        else
        begin
          {nxt_st.cnt_hi, nxt_st.cnt_lo} = cnt32 + 32'h0000_0001; // RQ1
        end
      end
    end
    else
    begin
      if (st_ff.tick_lo)
      begin
        if (st_ff.cnt_lo == st_ff.per_lo)
        begin
          nxt_st.cnt_lo = 16'h0000; // RQ6
          set_v[tcp_pkg::STS_LO] = 1'b1;
          nxt_st.adc = 1'b1; // RQ15
        end
        else
          nxt_st.cnt_lo = st_ff.cnt_lo + 16'h0001;
      end
      if (hit_hi)
      begin
        if (st_ff.cnt_hi == st_ff.per_hi)
        begin
          nxt_st.cnt_hi = 16'h0000; // RQ6
          set_v[tcp_pkg::STS_HI] = 1'b1;
        end
        else
          nxt_st.cnt_hi = st_ff.cnt_hi + 16'h0001;
      end
    end
    // bus writes in the data phase; a write beats a count step
    if (wr)
    begin
      unique case (st_ff.ap_adr)
        tcp_pkg::OFS_CTL_LO: nxt_st.ctl_lo = wd & tcp_pkg::CTL_MASK;
        tcp_pkg::OFS_CTL_HI: nxt_st.ctl_hi = wd & tcp_pkg::CTL_MASK;
        tcp_pkg::OFS_CNT_LO:
        begin
          nxt_st.cnt_lo = wd;
          if (casc)
            nxt_st.cnt_hi = st_ff.hold; // RQ12
        end
        tcp_pkg::OFS_CNT_HI: nxt_st.cnt_hi = wd;
        tcp_pkg::OFS_PER_LO: nxt_st.per_lo = wd;
        tcp_pkg::OFS_PER_HI: nxt_st.per_hi = wd;
        tcp_pkg::OFS_HOLD: nxt_st.hold = wd; // RQ12
        tcp_pkg::OFS_STS: clr_v = wd[1:0];
        tcp_pkg::OFS_MSK: nxt_st.msk = wd[1:0];
        default: nxt_st.msk = st_ff.msk;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    nxt_st.sts = (st_ff.sts & ~clr_v) | set_v;
    // address phase: zero wait states, read data registered here
    nxt_st.ap_vld = i_hsel & i_htrans[1] & i_hready;
    nxt_st.ap_wr = i_hwrite;
    nxt_st.ap_adr = i_haddr[7:0];
    if (rd_acc)
    begin
      nxt_st.rdata = tcp_rd(st_ff, i_haddr[7:0]);
      if (i_haddr[7:0] == tcp_pkg::OFS_CNT_LO)
        nxt_st.hold = st_ff.cnt_hi; // RQ11
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.ctl_lo <= tcp_pkg::CTL_RST;
      st_ff.ctl_hi <= tcp_pkg::CTL_RST;
      st_ff.per_lo <= tcp_pkg::PER_RST;
      st_ff.per_hi <= tcp_pkg::PER_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign o_hrdata = st_ff.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_adc_trig = st_ff.adc;
  assign o_irq = |(st_ff.sts & st_ff.msk); // RQ4

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  chk_casc_wrap: assert property ( // RQ9
    casc && st_ff.tick_lo && !wr_cnt && cnt32 == per32
    |=> {st_ff.cnt_hi, st_ff.cnt_lo} == 32'h0000_0000)
    else $error("cascade did not wrap at period");
  chk_casc_step: assert property ( // RQ1
    casc && st_ff.tick_lo && !wr_cnt && cnt32 != per32
    |=> {st_ff.cnt_hi, st_ff.cnt_lo} == $past(cnt32) + 32'h0000_0001)
    else $error("cascade count did not carry");
  chk_casc_flag: assert property ( // RQ5
    casc && st_ff.tick_lo && cnt32 == per32
    |=> st_ff.sts[tcp_pkg::STS_HI] ##0 st_ff.adc)
    else $error("32-bit match raised no high flag");
  chk_half_quiet: assert property ( // RQ16
    casc && !st_ff.sts[tcp_pkg::STS_LO] |=> !st_ff.sts[tcp_pkg::STS_LO])
    else $error("half match flagged while cascaded");
  chk_hi_ignored: assert property ( // RQ2
    casc |=> st_ff.pre_hi == 8'h00)
    else $error("high prescaler ran while cascaded");
  chk_low_retime: assert property ( // RQ8
    hit_lo ##1 (!casc && !wr_cnt && st_ff.cnt_lo != st_ff.per_lo)
    |=> st_ff.cnt_lo == $past(st_ff.cnt_lo) + 16'h0001)
    else $error("low count step not one cycle after prescaler");
  chk_hold_copy: assert property ( // RQ11
    rd_acc && i_haddr[7:0] == tcp_pkg::OFS_CNT_LO
    |=> st_ff.hold == $past(st_ff.cnt_hi))
    else $error("low count read did not latch high count");
  chk_hold_load: assert property ( // RQ12
    wr_lo && casc |=> st_ff.cnt_hi == $past(st_ff.hold))
    else $error("holding value not loaded into high count");
  chk_idle_stop: assert property ( // RQ13
    i_idle && st_ff.ctl_lo[tcp_pkg::CTL_SIDL] && st_ff.ctl_lo[tcp_pkg::CTL_ON]
    && !wr
    |=> $stable(st_ff.pre_lo) && !st_ff.tick_lo)
    else $error("low half advanced in idle");
  // non-cascaded halves: each wraps on its own period
  chk_lo_wrap: assert property ( // RQ6
    !casc && st_ff.tick_lo && !wr_cnt && st_ff.cnt_lo == st_ff.per_lo
    |=> st_ff.cnt_lo == 16'h0000 && st_ff.sts[tcp_pkg::STS_LO] && st_ff.adc)
    else $error("low half did not wrap at its period");
  chk_hi_wrap: assert property ( // RQ6
    !casc && hit_hi && !wr_cnt && st_ff.cnt_hi == st_ff.per_hi
    |=> st_ff.cnt_hi == 16'h0000 && st_ff.sts[tcp_pkg::STS_HI])
    else $error("high half did not wrap at its period");
  // a pin edge must pass the synchroniser before any tick
  chk_ext_edge: assert property ( // RQ10
    st_ff.ctl_lo[tcp_pkg::CTL_EXT] && !rise_lo |=> !st_ff.tick_lo)
    else $error("external mode ticked without a synced edge");
  chk_gate_low: assert property ( // RQ15
    !st_ff.ctl_lo[tcp_pkg::CTL_EXT] && st_ff.ctl_lo[tcp_pkg::CTL_GATE]
    && !st_ff.lv_lo |=> !st_ff.tick_lo)
    else $error("gated low half ticked with gate low");
  chk_set_wins: assert property ( // RQ5
    set_v[tcp_pkg::STS_HI] |=> st_ff.sts[tcp_pkg::STS_HI])
    else $error("high match flag lost to a clear");

  cov_casc_wrap: cover property (
    casc && st_ff.tick_lo && cnt32 == per32 ##1 o_irq);
  cov_hold_load: cover property (
    wr && st_ff.ap_adr == tcp_pkg::OFS_HOLD ##1 wr_lo && casc);
  cov_idle_resume: cover property (
    i_idle && st_ff.ctl_lo[tcp_pkg::CTL_SIDL] ##1 !i_idle ##[1:4] hit_lo);
  cov_gate_count: cover property (
    st_ff.ctl_lo[tcp_pkg::CTL_GATE] && st_ff.lv_lo ##1 st_ff.tick_lo);
  cov_hi_prescale: cover property (
    !casc && st_ff.ctl_hi[tcp_pkg::CTL_PS+:2] != 2'h0 && hit_hi);
endmodule

// ---- dv/tcp_pin_drv.sv ----
// external clock or gate pin model for one timer half
`timescale 1ns/10ps
module tcp_pin_drv (
  // clock
  input wire logic i_clock,
  // pin
  output logic o_pin
);
  initial o_pin = 1'b0;
  // pin rests low between bursts so no stray edge is seen
  task automatic pulses(input int n, input int half);
    repeat (n)
    begin
      @(posedge i_clock);
      o_pin <= 1'b1;
      repeat (half) @(posedge i_clock);
      o_pin <= 1'b0;
      repeat (half) @(posedge i_clock);
    end
  endtask
endmodule

// ---- dv/tcp_timer_pair_tb.sv ----
// self-checking bench for the timer pair
`timescale 1ns/10ps
`define CK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tcp_timer_pair_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hrdy, hresp, idle = 1'b0, pin, pin_hi, adc, irq;
  int err_count = 0, n_checks = 0, cyc = 0, adc_n = 0;
  initial forever #50 clock = ~clock;
  tcp_pin_drv PIN (.i_clock(clock), .o_pin(pin));
  tcp_pin_drv PINH (.i_clock(clock), .o_pin(pin_hi));
  tcp_timer_pair DUT (.i_clock(clock), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_ext_clk_lo(pin), .i_ext_clk_hi(pin_hi), .i_idle(idle),
    .o_adc_trig(adc), .o_irq(irq));
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (adc === 1'b1) adc_n <= adc_n + 1;
    // generous ceiling: the whole run needs well under a thousand cycles
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clock);
    while (hrdy !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hrdy !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CK(nm, e, rd)
    `CK("hresp", 1'b0, hresp)
  endtask
  task automatic t_reset();
    rc("ctl_lo", tcp_pkg::OFS_CTL_LO, 32'h0);
    rc("per_lo", tcp_pkg::OFS_PER_LO, 32'hFFFF);
    rc("cnt_hi", tcp_pkg::OFS_CNT_HI, 32'h0);
    wr(8'h40, 32'h1234);
    rc("unmapped", 8'h40, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_halves();
    wr(tcp_pkg::OFS_PER_LO, 32'h3);
    wr(tcp_pkg::OFS_MSK, 32'h1);
    wr(tcp_pkg::OFS_CTL_LO, 32'h8000);
    repeat (20) @(posedge clock);
    `CK("adc", 1'b1, adc_n > 0)
    `CK("irq_on", 1'b1, irq)
    wr(tcp_pkg::OFS_CTL_LO, 32'h0);
    wr(tcp_pkg::OFS_MSK, 32'h0);
    // irq is a gate of registers that change on this edge: look later
    @(negedge clock);
    `CK("irq_mask", 1'b0, irq)
    rc("sts_lo", tcp_pkg::OFS_STS, 32'h1);
    wr(tcp_pkg::OFS_STS, 32'h3);
    wr(tcp_pkg::OFS_PER_HI, 32'h2);
    wr(tcp_pkg::OFS_CTL_HI, 32'h8000);
    repeat (10) @(posedge clock);
    wr(tcp_pkg::OFS_CTL_HI, 32'h0);
    rc("sts_hi", tcp_pkg::OFS_STS, 32'h2);
    wr(tcp_pkg::OFS_STS, 32'h3);
    rc("sts_clr", tcp_pkg::OFS_STS, 32'h0);
    $display("test halves done");
  endtask
  task automatic t_cascade();
    int adc0;
    wr(tcp_pkg::OFS_CTL_LO, 32'h0008);
    wr(tcp_pkg::OFS_CTL_HI, 32'h8000);
    wr(tcp_pkg::OFS_PER_LO, 32'h5);
    wr(tcp_pkg::OFS_PER_HI, 32'h0);
    wr(tcp_pkg::OFS_HOLD, 32'h1);
    wr(tcp_pkg::OFS_CNT_LO, 32'h3);
    wr(tcp_pkg::OFS_CTL_LO, 32'h8008);
    repeat (12) @(posedge clock);
    rc("no_half_match", tcp_pkg::OFS_STS, 32'h0);
    wr(tcp_pkg::OFS_CTL_LO, 32'h0008);
    wr(tcp_pkg::OFS_PER_HI, 32'h1);
    wr(tcp_pkg::OFS_PER_LO, 32'h2);
    wr(tcp_pkg::OFS_HOLD, 32'h0);
    wr(tcp_pkg::OFS_CNT_LO, 32'hFFFE);
    wr(tcp_pkg::OFS_MSK, 32'h2);
    adc0 = adc_n;
    wr(tcp_pkg::OFS_CTL_LO, 32'h8008);
    repeat (10) @(posedge clock);
    `CK("irq32", 1'b1, irq)
    `CK("adc32", 1'b1, adc_n > adc0)
    wr(tcp_pkg::OFS_CTL_LO, 32'h0008);
    rc("sts32", tcp_pkg::OFS_STS, 32'h2);
    wr(tcp_pkg::OFS_STS, 32'h3);
    wr(tcp_pkg::OFS_MSK, 32'h0);
    wr(tcp_pkg::OFS_HOLD, 32'h7);
    wr(tcp_pkg::OFS_CNT_LO, 32'h1234);
    rc("lo_word", tcp_pkg::OFS_CNT_LO, 32'h1234);
    rc("hold", tcp_pkg::OFS_HOLD, 32'h7);
    rc("hi_word", tcp_pkg::OFS_CNT_HI, 32'h7);
    $display("test cascade done");
  endtask
  task automatic t_count_idle();
    wr(tcp_pkg::OFS_PER_LO, 32'hFFFF);
    wr(tcp_pkg::OFS_PER_HI, 32'hFFFF);
    wr(tcp_pkg::OFS_HOLD, 32'h0);
    wr(tcp_pkg::OFS_CNT_LO, 32'hFFFE);
    wr(tcp_pkg::OFS_CTL_LO, 32'hA00A);
    PIN.pulses(4, 3);
    repeat (10) @(posedge clock);
    rc("ext_lo", tcp_pkg::OFS_CNT_LO, 32'h2);
    rc("ext_hold", tcp_pkg::OFS_HOLD, 32'h1);
    idle <= 1'b1;
    PIN.pulses(3, 3);
    repeat (10) @(posedge clock);
    rc("idle_frozen", tcp_pkg::OFS_CNT_LO, 32'h2);
    idle <= 1'b0;
    PIN.pulses(2, 3);
    repeat (10) @(posedge clock);
    rc("resumed", tcp_pkg::OFS_CNT_LO, 32'h4);
    $display("test count_idle done");
  endtask
  task automatic t_modes();
    wr(tcp_pkg::OFS_CTL_HI, 32'h0);
    wr(tcp_pkg::OFS_CTL_LO, 32'h0);
    wr(tcp_pkg::OFS_CNT_LO, 32'h0);
    wr(tcp_pkg::OFS_CNT_HI, 32'h0);
    // high half: external edges through the divide-by-8 prescaler
    wr(tcp_pkg::OFS_CTL_HI, 32'h8012);
    // low half: internal cycles counted while its pin gate is high
    wr(tcp_pkg::OFS_CTL_LO, 32'h8040);
    PINH.pulses(16, 2);
    PIN.pulses(1, 20);
    repeat (10) @(posedge clock);
    rc("hi_ps8", tcp_pkg::OFS_CNT_HI, 32'h2);
    rc("lo_gate", tcp_pkg::OFS_CNT_LO, 32'h14);
    $display("test modes done");
  endtask
  task automatic t_reset_mid();
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rc("rst_ctl_hi", tcp_pkg::OFS_CTL_HI, 32'h0);
    rc("rst_cnt_lo", tcp_pkg::OFS_CNT_LO, 32'h0);
    rc("rst_per_hi", tcp_pkg::OFS_PER_HI, 32'hFFFF);
    `CK("rst_irq", 1'b0, irq)
    $display("test reset_mid done");
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_halves();
    t_cascade();
    t_count_idle();
    t_modes();
    t_reset_mid();
    conclude();
  end
endmodule
